// ---- rtl/sslc_pkg.sv ----
// Constants, types and field layout of the strap latch and clock configuration block
package sslc_pkg;
   // Register byte offsets
   localparam logic [11:0] REG_STRAP_STATUS = 12'h000;
   localparam logic [11:0] REG_GEN_CTRL = 12'h004;
   localparam logic [11:0] REG_CLK_CTRL = 12'h008;
   localparam logic [11:0] REG_MODE_STATUS = 12'h00C;
   // General control fields
   localparam int GC_CPU_DIS = 0;
   localparam int GC_CPU_BE = 1;
   localparam int GC_BOOT_MODE = 2;
   localparam int GC_SI_MST = 3;
   localparam int GC_MIIM_SLV = 4;
   localparam int GC_WIDTH = 5;
   localparam logic [4:0] GC_RESET = 5'h01;
   // Clock control fields
   localparam int CC_SECOND_EN = 0;
   localparam int CC_DIV_PRI_LSB = 1;
   localparam int CC_DIV_SEC_LSB = 4;
   localparam logic [2:0] CORE_DIV_RESET = 3'h1;
   // Second synthesizer reference frequency codes
   localparam logic [2:0] FREQ_125 = 3'h0;
   localparam logic [2:0] FREQ_156 = 3'h1;
   localparam logic [2:0] FREQ_250 = 3'h2;
   localparam logic [2:0] FREQ_25 = 3'h4;
   // Startup codes
   localparam logic [3:0] MODE_BOOT_LE = 4'h0;
   localparam logic [3:0] MODE_PCIE_P10 = 4'h1;
   localparam logic [3:0] MODE_PCIE_P6 = 4'h2;
   localparam logic [3:0] MODE_PCIE_P0 = 4'h3;
   localparam logic [3:0] MODE_PCIE_P10_N9 = 4'h4;
   localparam logic [3:0] MODE_PCIE_N9 = 4'h5;
   localparam logic [3:0] MODE_PCIE_N4 = 4'h8;
   localparam logic [3:0] MODE_PCIE_ONLY = 4'h9;
   localparam logic [3:0] MODE_MIIM_0 = 4'hA;
   localparam logic [3:0] MODE_MIIM_31 = 4'hB;
   localparam logic [3:0] MODE_BOOT_BE = 4'hC;
   localparam logic [3:0] MODE_IDLE = 4'hF;
   localparam logic [3:0] PORT_NUM_0 = 4'h0;
   localparam logic [3:0] PORT_NUM_4 = 4'h4;
   localparam logic [3:0] PORT_NUM_6 = 4'h6;
   localparam logic [3:0] PORT_NUM_9 = 4'h9;
   localparam logic [3:0] PORT_NUM_10 = 4'hA;
   localparam logic [4:0] MIIM_ADDR_31 = 5'h1F;

   typedef enum logic [3:0] {
      ST_WAIT = 4'b0001,
      ST_DECODE = 4'b0010,
      ST_LOAD = 4'b0100,
      ST_RUN = 4'b1000
   } sslc_state_t;

   typedef struct packed {
      logic pcie_en;
      logic frame_access_en;
      logic npi_en;
      logic [3:0] npi_port;
      logic npi_10g;
      logic front_en;
      logic [3:0] front_port;
      logic front_10g;
   } sslc_port_cfg_t;

   typedef struct packed {
      logic cpu_en;
      logic cpu_be;
      logic boot_flash;
      logic miim_slave_en;
      logic [4:0] miim_addr;
      logic reserved_code;
      sslc_port_cfg_t port;
   } sslc_boot_cfg_t;
endpackage : sslc_pkg

// ---- rtl/sslc_cfg_if.sv ----
// Interface between the strap sequencer and the startup mode decoder
`timescale 1ns/100ps
`default_nettype none
interface sslc_cfg_if;
   import sslc_pkg::*;
   logic [3:0] code;
   logic start;
   sslc_boot_cfg_t cfg;
   logic valid;
   modport seq (output code, output start, input cfg, input valid);
   modport dec (input code, input start, output cfg, output valid);
endinterface : sslc_cfg_if
`default_nettype wire

// ---- rtl/sslc_mode_decode.sv ----
// Startup code decoder with registered boot configuration
`timescale 1ns/100ps
`default_nettype none
module sslc_mode_decode (
   input wire logic ref_clk,
   input wire logic reset,
   sslc_cfg_if.dec cif
);
   import sslc_pkg::*;

   sslc_boot_cfg_t cfg_next;

   always_comb begin
      cfg_next = '0;
      case (cif.code)
         MODE_BOOT_LE, MODE_BOOT_BE: begin
            cfg_next.cpu_en = 1'b1;
            cfg_next.boot_flash = 1'b1;
            cfg_next.cpu_be = (cif.code == MODE_BOOT_BE);
         end
         MODE_PCIE_P10, MODE_PCIE_P6, MODE_PCIE_P0: begin
            cfg_next.port.pcie_en = 1'b1;
            cfg_next.port.frame_access_en = 1'b1;
            cfg_next.port.npi_en = 1'b1;
            cfg_next.port.npi_port = PORT_NUM_4;
            cfg_next.port.front_en = 1'b1;
            cfg_next.port.front_10g = (cif.code == MODE_PCIE_P10);
            cfg_next.port.front_port = (cif.code == MODE_PCIE_P10) ? PORT_NUM_10 :
                                       (cif.code == MODE_PCIE_P6) ? PORT_NUM_6 : PORT_NUM_0;
         end
         MODE_PCIE_P10_N9, MODE_PCIE_N9: begin
            cfg_next.port.pcie_en = 1'b1;
            cfg_next.port.frame_access_en = 1'b1;
            cfg_next.port.npi_en = 1'b1;
            cfg_next.port.npi_port = PORT_NUM_9;
            cfg_next.port.npi_10g = 1'b1;
            cfg_next.port.front_en = (cif.code == MODE_PCIE_P10_N9);
            cfg_next.port.front_port = (cif.code == MODE_PCIE_P10_N9) ? PORT_NUM_10 : PORT_NUM_0;
            cfg_next.port.front_10g = (cif.code == MODE_PCIE_P10_N9);
         end
         MODE_PCIE_N4: begin
            cfg_next.port.pcie_en = 1'b1;
            cfg_next.port.frame_access_en = 1'b1;
            cfg_next.port.npi_en = 1'b1;
            cfg_next.port.npi_port = PORT_NUM_4;
         end
         MODE_PCIE_ONLY: begin
            cfg_next.port.pcie_en = 1'b1;
         end
         MODE_MIIM_0, MODE_MIIM_31: begin
            cfg_next.miim_slave_en = 1'b1;
            cfg_next.miim_addr = (cif.code == MODE_MIIM_31) ? MIIM_ADDR_31 : 5'h00;
         end
         MODE_IDLE: begin
            cfg_next.cpu_en = 1'b0;
         end
         default: begin
            cfg_next.reserved_code = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cif.cfg <= '0;
         cif.valid <= 1'b0;
      end else if (cif.start) begin
         cif.cfg <= cfg_next;
         cif.valid <= 1'b1;
      end
   end

   a_npi_port_p10 : assert property (@(posedge ref_clk) disable iff (reset)
      cif.start && cif.code == MODE_PCIE_P10 |=> cif.cfg.port.npi_port == PORT_NUM_4
         && cif.cfg.port.front_port == PORT_NUM_10 && cif.cfg.port.front_10g)
      else $error("Code 0001 port setup wrong");
   a_miim_addr_31 : assert property (@(posedge ref_clk) disable iff (reset)
      cif.start && cif.code == MODE_MIIM_31 |=> cif.cfg.miim_slave_en
         && cif.cfg.miim_addr == MIIM_ADDR_31 && !cif.cfg.boot_flash)
      else $error("Code 1011 MIIM setup wrong");
   a_idle_mode : assert property (@(posedge ref_clk) disable iff (reset)
      cif.start && cif.code == MODE_IDLE |=> cif.cfg == '0)
      else $error("Code 1111 enabled something");
endmodule : sslc_mode_decode
`default_nettype wire

// ---- rtl/sslc_top.sv ----
// Strap latch, clock selection and boot configuration with APB registers
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sslc_top (
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Straps
   input wire logic second_synth_select_strap,
   input wire logic [2:0] second_synth_freq_strap,
   input wire logic [2:0] primary_synth_freq_strap,
   // Startup strap pins shared with general-purpose functions
   input wire logic [3:0] startup_pin_in,
   output logic [3:0] startup_pin_out,
   output logic [3:0] startup_pin_oe,
   input wire logic [3:0] gpio_func_out,
   input wire logic [3:0] gpio_func_oe,
   output logic [3:0] gpio_func_in,
   // Readiness of the enabled host path
   input wire logic front_port_ready,
   input wire logic pcie_ready,
   // Clock tree
   output logic core_clk_sel_second,
   output logic cpu_serdes_clk_sel_second,
   output logic second_synth_power_en,
   output logic [2:0] second_synth_freq_code,
   output logic second_synth_freq_valid,
   output logic [2:0] primary_synth_freq_code,
   output logic [2:0] primary_core_clk_div,
   output logic [2:0] second_core_clk_div,
   // Boot and host interfaces
   output logic cpu_enable,
   output logic cpu_big_endian,
   output logic boot_from_flash,
   output logic si_slave_enable,
   output logic miim_slave_enable,
   output logic [4:0] miim_slave_addr,
   output sslc_pkg::sslc_port_cfg_t port_cfg,
   output logic config_ready
);
   import sslc_pkg::*;

   sslc_state_t state_reg;
   sslc_state_t state_next;
   logic [3:0] startup_code_reg;
   logic sel_strap_reg;
   logic [2:0] sec_freq_strap_reg;
   logic [2:0] pri_freq_strap_reg;
   logic [GC_WIDTH-1:0] gen_ctrl_reg;
   logic second_reg_en_reg;
   logic [2:0] div_pri_reg;
   logic [2:0] div_sec_reg;
   logic ready_seen_reg;
   logic apb_access;
   logic apb_commit;
   logic host_path_on;
   logic second_on;
   logic [31:0] rdata_next;
   logic slverr_next;

   sslc_cfg_if cif ();

   sslc_mode_decode u_decode (
      .ref_clk(ref_clk),
      .reset(reset),
      .cif(cif.dec)
   );

   // Startup sequence: capture, decode, load, run
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_WAIT: state_next = ST_DECODE;
         ST_DECODE: state_next = ST_LOAD;
         ST_LOAD: state_next = ST_RUN;
         ST_RUN: state_next = ST_RUN;
         default: state_next = ST_WAIT;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_WAIT;
      end else begin
         state_reg <= state_next;
      end
   end

   // Straps are sampled on the first edge after reset release only
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         startup_code_reg <= 4'h0;
         sel_strap_reg <= 1'b0;
         sec_freq_strap_reg <= 3'h0;
         pri_freq_strap_reg <= 3'h0;
      end else if (state_reg == ST_WAIT) begin
         startup_code_reg <= startup_pin_in;
         sel_strap_reg <= second_synth_select_strap;
         sec_freq_strap_reg <= second_synth_freq_strap;
         pri_freq_strap_reg <= primary_synth_freq_strap;
      end
   end

   assign cif.code = startup_code_reg;
   assign cif.start = (state_reg == ST_DECODE);

   // APB slave: one wait state, answer on the second access cycle
   assign apb_access = psel && penable && !pready;
   assign apb_commit = psel && penable && pready;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         gen_ctrl_reg <= GC_RESET;
      end else if (state_reg == ST_LOAD) begin
         gen_ctrl_reg[GC_CPU_DIS] <= !cif.cfg.cpu_en;
         gen_ctrl_reg[GC_CPU_BE] <= cif.cfg.cpu_be;
         gen_ctrl_reg[GC_BOOT_MODE] <= cif.cfg.boot_flash;
         gen_ctrl_reg[GC_SI_MST] <= cif.cfg.boot_flash;
         gen_ctrl_reg[GC_MIIM_SLV] <= cif.cfg.miim_slave_en;
      end else if (apb_commit && pwrite && paddr == REG_GEN_CTRL) begin
         gen_ctrl_reg <= pwdata[GC_WIDTH-1:0];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         second_reg_en_reg <= 1'b0;
         div_pri_reg <= CORE_DIV_RESET;
         div_sec_reg <= CORE_DIV_RESET;
      end else if (apb_commit && pwrite && paddr == REG_CLK_CTRL) begin
         second_reg_en_reg <= pwdata[CC_SECOND_EN];
         div_pri_reg <= pwdata[CC_DIV_PRI_LSB +: 3];
         div_sec_reg <= pwdata[CC_DIV_SEC_LSB +: 3];
      end
   end

   always_comb begin
      rdata_next = 32'h0000_0000;
      slverr_next = 1'b0;
      if (paddr == REG_STRAP_STATUS) begin
         rdata_next[3:0] = startup_code_reg;
         rdata_next[6:4] = sec_freq_strap_reg;
         rdata_next[7] = sel_strap_reg;
         rdata_next[10:8] = pri_freq_strap_reg;
         rdata_next[11] = (state_reg == ST_RUN);
      end else if (paddr == REG_GEN_CTRL) begin
         rdata_next[GC_WIDTH-1:0] = gen_ctrl_reg;
      end else if (paddr == REG_CLK_CTRL) begin
         rdata_next[CC_SECOND_EN] = second_reg_en_reg;
         rdata_next[CC_DIV_PRI_LSB +: 3] = div_pri_reg;
         rdata_next[CC_DIV_SEC_LSB +: 3] = div_sec_reg;
      end else if (paddr == REG_MODE_STATUS) begin
         rdata_next[$bits(sslc_boot_cfg_t)-1:0] = cif.cfg;
         rdata_next[31] = ready_seen_reg;
      end else begin
         slverr_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_access;
         prdata <= (apb_access && !pwrite) ? rdata_next : 32'h0000_0000;
         pslverr <= apb_access && slverr_next;
      end
   end

   // Clock tree selection
   assign second_on = sel_strap_reg || second_reg_en_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         core_clk_sel_second <= 1'b0;
         cpu_serdes_clk_sel_second <= 1'b0;
         second_synth_power_en <= 1'b0;
         second_synth_freq_code <= FREQ_125;
         second_synth_freq_valid <= 1'b0;
         primary_synth_freq_code <= 3'h0;
         primary_core_clk_div <= CORE_DIV_RESET;
         second_core_clk_div <= CORE_DIV_RESET;
      end else begin
         core_clk_sel_second <= sel_strap_reg;
         cpu_serdes_clk_sel_second <= 1'b0;
         second_synth_power_en <= second_on;
         second_synth_freq_valid <= second_on;
         second_synth_freq_code <= second_on ? sec_freq_strap_reg : FREQ_125;
         primary_synth_freq_code <= pri_freq_strap_reg;
         primary_core_clk_div <= div_pri_reg;
         second_core_clk_div <= second_on ? div_sec_reg : CORE_DIV_RESET;
      end
   end

   // Boot and host configuration outputs
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cpu_enable <= 1'b0;
         cpu_big_endian <= 1'b0;
         boot_from_flash <= 1'b0;
         si_slave_enable <= 1'b0;
         miim_slave_enable <= 1'b0;
         miim_slave_addr <= 5'h00;
         port_cfg <= '0;
         config_ready <= 1'b0;
      end else begin
         cpu_enable <= !gen_ctrl_reg[GC_CPU_DIS] && state_reg == ST_RUN;
         cpu_big_endian <= gen_ctrl_reg[GC_CPU_BE];
         boot_from_flash <= gen_ctrl_reg[GC_BOOT_MODE] && gen_ctrl_reg[GC_SI_MST];
         si_slave_enable <= !gen_ctrl_reg[GC_SI_MST] && state_reg == ST_RUN;
         miim_slave_enable <= gen_ctrl_reg[GC_MIIM_SLV];
         miim_slave_addr <= cif.cfg.miim_addr;
         port_cfg <= cif.cfg.port;
         config_ready <= (state_reg == ST_RUN);
      end
   end

   // Strap pins: inputs until the run state, then general-purpose, upper pair marks readiness
   assign host_path_on = cif.cfg.port.front_en || cif.cfg.port.pcie_en;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ready_seen_reg <= 1'b0;
      end else if (state_reg == ST_RUN && host_path_on
                   && ((cif.cfg.port.front_en && front_port_ready)
                       || (cif.cfg.port.pcie_en && pcie_ready))) begin
         ready_seen_reg <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         startup_pin_out <= 4'h0;
         startup_pin_oe <= 4'h0;
         gpio_func_in <= 4'h0;
      end else if (state_reg == ST_RUN) begin
         startup_pin_out[1:0] <= gpio_func_out[1:0];
         startup_pin_oe[1:0] <= gpio_func_oe[1:0];
         startup_pin_out[3:2] <= ready_seen_reg ? 2'h3 : gpio_func_out[3:2];
         startup_pin_oe[3:2] <= ready_seen_reg ? 2'h3 : gpio_func_oe[3:2];
         gpio_func_in <= startup_pin_in;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_strap_capture : assert property (
      state_reg == ST_WAIT |=> state_reg == ST_DECODE
         && startup_code_reg == $past(startup_pin_in)
         && sel_strap_reg == $past(second_synth_select_strap))
      else $error("Straps not captured on release");
   a_strap_hold : assert property (
      state_reg != ST_WAIT |=> $stable(startup_code_reg) && $stable(sec_freq_strap_reg)
         && $stable(sel_strap_reg) && $stable(pri_freq_strap_reg))
      else $error("Captured strap changed");
   a_pins_released : assert property (
      state_reg == ST_RUN |=> startup_pin_oe[1:0] == $past(gpio_func_oe[1:0])
         && gpio_func_in == $past(startup_pin_in))
      else $error("Shared pins not returned");
   a_core_clk_sel : assert property (
      state_reg == ST_RUN && $past(state_reg == ST_RUN)
         |-> core_clk_sel_second == sel_strap_reg && !cpu_serdes_clk_sel_second)
      else $error("Core clock source wrong");
   a_second_power : assert property (
      !sel_strap_reg && !second_reg_en_reg ##1 !sel_strap_reg
         |-> !second_synth_power_en && !second_synth_freq_valid)
      else $error("Second synthesizer on without request");
   a_freq_25 : assert property (
      second_on && sec_freq_strap_reg == FREQ_25 |=> second_synth_freq_code == FREQ_25)
      else $error("25 MHz code lost");
   a_gen_ctrl_load : assert property (
      state_reg == ST_LOAD |=> gen_ctrl_reg[GC_CPU_DIS] == !$past(cif.cfg.cpu_en)
         && gen_ctrl_reg[GC_SI_MST] == $past(cif.cfg.boot_flash))
      else $error("General control not loaded from strap");
   a_boot_le_flash : assert property (
      state_reg == ST_LOAD && startup_code_reg == MODE_BOOT_LE
         |=> ##2 cpu_enable && !cpu_big_endian && boot_from_flash && !si_slave_enable)
      else $error("Little endian flash boot wrong");
   a_ready_pins : assert property (
      ready_seen_reg && state_reg == ST_RUN |=> startup_pin_oe[3:2] == 2'h3
         && startup_pin_out[3:2] == 2'h3)
      else $error("Ready pins not driven");
   a_apb_answer : assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("APB answer timing wrong");

   c_flash_boot : cover property (state_reg == ST_LOAD && startup_code_reg == MODE_BOOT_LE);
   c_pcie_ready : cover property (ready_seen_reg && port_cfg.pcie_en);
   c_miim_mode : cover property (miim_slave_enable && miim_slave_addr == MIIM_ADDR_31);
   c_clk_write : cover property (apb_commit && pwrite && paddr == REG_CLK_CTRL);
endmodule : sslc_top
`default_nettype wire

// ---- verif/sslc_board_model.sv ----
// Board strap resistors on the shared startup pins
`timescale 1ns/100ps
`default_nettype none
module sslc_board_model (
   input wire logic [3:0] strap_code,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   output logic [3:0] pin_in
);
   // Resistors pull each pin to its strap level whenever the device lets go
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & strap_code);
endmodule : sslc_board_model
`default_nettype wire

// ---- verif/tb_sslc_top.sv ----
// Self-checking bench for the strap latch and clock configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_sslc_top;
   import sslc_pkg::*;
   typedef struct packed {
      logic [3:0] code;
      logic cpu, be, fl, si, mi;
      logic [4:0] ad;
      logic pc, ne;
      logic [3:0] np;
      logic fe;
      logic [3:0] fp;
   } sslc_row_t;
   logic ref_clk, reset, psel, penable, pwrite, sel, fr_rdy, pc_rdy, pready, pslverr, err;
   logic core_sel, cs_sel, pwr_en, fq_valid, cpu_en, cpu_be, flash, si_en, mi_en, ready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] fq, pfq, fq_code, pfq_code, div_p, div_s;
   logic [3:0] strap, pin_in, pin_out, pin_oe, g_out, g_oe, g_in;
   logic [4:0] mi_addr;
   logic [2:0] fqs [4];
   sslc_port_cfg_t port_cfg;
   sslc_row_t rows [12];
   int miscompares = 0;
   int cmp_count = 0;
   wire logic [23:0] got_cfg = {cpu_en, cpu_be, flash, si_en, mi_en, mi_addr, port_cfg};

   sslc_top u_sslc_top (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .second_synth_select_strap(sel), .second_synth_freq_strap(fq),
      .primary_synth_freq_strap(pfq), .startup_pin_in(pin_in), .startup_pin_out(pin_out),
      .startup_pin_oe(pin_oe), .gpio_func_out(g_out), .gpio_func_oe(g_oe),
      .gpio_func_in(g_in), .front_port_ready(fr_rdy), .pcie_ready(pc_rdy),
      .core_clk_sel_second(core_sel), .cpu_serdes_clk_sel_second(cs_sel),
      .second_synth_power_en(pwr_en), .second_synth_freq_code(fq_code),
      .second_synth_freq_valid(fq_valid), .primary_synth_freq_code(pfq_code),
      .primary_core_clk_div(div_p), .second_core_clk_div(div_s), .cpu_enable(cpu_en),
      .cpu_big_endian(cpu_be), .boot_from_flash(flash), .si_slave_enable(si_en),
      .miim_slave_enable(mi_en), .miim_slave_addr(mi_addr), .port_cfg(port_cfg),
      .config_ready(ready));
   sslc_board_model u_sslc_board_model (.strap_code(strap), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_in(pin_in));

   function automatic logic [23:0] exp_of(input sslc_row_t r);
      return {r.cpu, r.be, r.fl, r.si, r.mi, r.ad, r.pc, r.ne, r.ne, r.np, r.np == 4'h9,
         r.fe, r.fp, r.fe && r.fp == 4'hA};
   endfunction : exp_of
   task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask : chk
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic boot(input logic [3:0] c, input logic s, input logic [2:0] f);
      int n;
      @(posedge ref_clk);
      reset <= 1'h1;
      strap <= c;
      sel <= s;
      fq <= f;
      fr_rdy <= 1'h0;
      repeat (4) @(posedge ref_clk);
      reset <= 1'h0;
      for (n = 0; n < 20 && ready !== 1'h1; n++) @(posedge ref_clk);
      if (n == 20) begin
         miscompares++;
         complete_run();
      end
      @(posedge ref_clk);
   endtask : boot
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      for (n = 0; n < 20 && pready !== 1'h1; n++) @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n == 20) begin
         miscompares++;
         complete_run();
      end
   endtask : apb

   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      {reset, psel, penable, pwrite, paddr, pwdata, sel, fq} <= {1'h1, 51'h0};
      {pfq, strap, g_out, g_oe, fr_rdy, pc_rdy} <= 17'h0_4000;
      fqs = '{FREQ_125, FREQ_156, FREQ_250, FREQ_25};
      rows = '{'{MODE_BOOT_LE, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0},
         '{MODE_PCIE_P10, 0, 0, 0, 1, 0, 0, 1, 1, 4, 1, 10},
         '{MODE_PCIE_P6, 0, 0, 0, 1, 0, 0, 1, 1, 4, 1, 6},
         '{MODE_PCIE_P0, 0, 0, 0, 1, 0, 0, 1, 1, 4, 1, 0},
         '{MODE_PCIE_P10_N9, 0, 0, 0, 1, 0, 0, 1, 1, 9, 1, 10},
         '{MODE_PCIE_N9, 0, 0, 0, 1, 0, 0, 1, 1, 9, 0, 0},
         '{MODE_PCIE_N4, 0, 0, 0, 1, 0, 0, 1, 1, 4, 0, 0},
         '{MODE_PCIE_ONLY, 0, 0, 0, 1, 0, 0, 1, 0, 0, 0, 0},
         '{MODE_MIIM_0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 0, 0},
         '{MODE_MIIM_31, 0, 0, 0, 1, 1, 31, 0, 0, 0, 0, 0},
         '{MODE_BOOT_BE, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0},
         '{MODE_IDLE, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0}};
      foreach (rows[i]) begin
         boot(rows[i].code, 1'h1, fqs[i % 4]);
         chk("boot cfg", exp_of(rows[i]), got_cfg);
         chk("freq code", {1'h1, fqs[i % 4]}, {fq_valid, fq_code});
      end
      boot(MODE_PCIE_P10, 1'h1, FREQ_156);
      strap <= 4'h5;
      repeat (3) @(posedge ref_clk);
      chk("held cfg", exp_of(rows[1]), got_cfg);
      chk("gpio in", 4'h5, g_in);
      chk("clock sel", {3'h5, FREQ_156, 3'h1}, {core_sel, cs_sel, pwr_en, fq_code, pfq_code});
      chk("pin oe idle", 4'h0, pin_oe);
      fr_rdy <= 1'h1;
      g_oe <= 4'h1;
      g_out <= 4'h1;
      repeat (4) @(posedge ref_clk);
      chk("ready pins", 6'h3F, {pin_oe[3:2], pin_in[3:2], pin_oe[0], pin_out[0]});
      g_oe <= 4'h0;
      apb(1'h1, REG_STRAP_STATUS, 32'hFFFF_FFFF);
      apb(1'h0, REG_STRAP_STATUS, 32'h0);
      chk("status", {20'h0, 1'h1, 3'h1, 1'h1, FREQ_156, MODE_PCIE_P10}, rd);
      apb(1'h0, 12'h010, 32'h0);
      chk("unmapped", 33'h1_0000_0000, {err, rd});
      apb(1'h0, REG_GEN_CTRL, 32'h0);
      chk("gen ctrl", 32'h0000_0001, rd);
      apb(1'h1, REG_GEN_CTRL, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk("cpu on", 1'h1, cpu_en);
      boot(MODE_BOOT_BE, 1'h0, FREQ_250);
      chk("clock off", 5'h00, {core_sel, pwr_en, fq_code});
      fr_rdy <= 1'h1;
      apb(1'h0, REG_GEN_CTRL, 32'h0);
      chk("gen ctrl be", 32'h0000_000E, rd);
      chk("no port pins", 2'h0, pin_oe[3:2]);
      apb(1'h1, REG_CLK_CTRL, 32'h0000_0037);
      repeat (3) @(posedge ref_clk);
      chk("clk ctrl", 7'h5B, {pwr_en, div_p, div_s});
      boot(MODE_PCIE_ONLY, 1'h0, FREQ_125);
      pc_rdy <= 1'h1;
      repeat (4) @(posedge ref_clk);
      chk("pcie ready pins", 4'hF, {pin_oe[3:2], pin_out[3:2]});
      apb(1'h0, REG_MODE_STATUS, 32'h0);
      chk("mode status", 32'h8000_2000, rd);
      complete_run();
   end
endmodule : tb_sslc_top
`default_nettype wire
